// File: rtl/icr_clk_gate.sv
// Operating clock enable from selected source, divider and gating.
`timescale 1ns/100ps
`include "icr_map.svh"
module icr_clk_gate
  import icr_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic run,
  icr_ev_if.gate    ev
);
  logic [2:0] cnt;
  logic [2:0] lim;

  always_comb begin
    lim = 3'h0;
    if (ev.src_sel == ICR_SRC_INTERNAL || ev.src_sel == ICR_SRC_FAST) begin // see RQ12
      case (ev.div_sel)
        2'h1:    lim = 3'h1;
        2'h2:    lim = 3'h3;
        2'h3:    lim = 3'h7;
        default: lim = 3'h0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst || !run) begin
      cnt <= 3'h0;
    end else if (ev.src_tick) begin
      cnt <= (cnt >= lim) ? 3'h0 : cnt + 3'h1;
    end
  end

  assign ev.clk_en = run && ev.src_tick && (cnt >= lim); // see RQ22
endmodule // icr_clk_gate

// File: rtl/icr_ev_if.sv
// Clock source, divider, tick and enable bundle between register block and clock gate.
`timescale 1ns/100ps
interface icr_ev_if;
  logic       clk_en;
  logic       src_tick;
  logic [1:0] src_sel;
  logic [1:0] div_sel;
  modport gate (input src_tick, input src_sel, input div_sel,
                output clk_en);
  modport regs (output src_sel, output div_sel, output src_tick,
                input clk_en);
endinterface

// File: rtl/icr_map.svh
// Register map, field positions and reset values for the two-wire controller registers.
// Behaviour
// RQ1: Byte-done flag set after byte plus ack.
// RQ2: General-call flag set in slave role only.
// RQ3: Nack-received flag set on received nack.
// RQ4: Stop-seen set after stop plus free time.
// RQ5: Start-seen set on start or address match.
// RQ6: Master tx-empty set on start or ack.
// RQ7: Slave tx-empty set on load or read match.
// RQ8: Rx-full set on load, cleared on read.
// RQ9: Interrupt needs flag and its enable bit.
// RQ10: DMA request needs flag and channel enable.
// RQ11: Software never enables DMA and interrupt together.
// RQ12: Clock source and divider code mapping.
// RQ13: Run-in-debug bit keeps clock during debug.
// RQ14: Software changes setup only while unit disabled.
// RQ15: Wide-address bit selects ten or seven bits.
// RQ16: General-call respond bit gates general calls.
// RQ17: Baud reload resets to 0x7f, never zero.
// RQ18: Role select bit five chooses master role.
// RQ19: Send-nack bit pends until nack is sent.
// RQ20: Start and stop requests self-clear, master only.
// RQ21: Soft reset clears engine and flags, self-clears.
// RQ22: Unit enable gates the operating clock.
// RQ23: Software writes transmit data only when empty.
// RQ24: Flag register bit layout, write one clears.
// RQ25: Interrupt enables share the flag bit layout.
// RQ26: Two sixteen-bit DMA enable registers.
`ifndef ICR_MAP_SVH
`define ICR_MAP_SVH
`define ICR_OFF_CLK      12'h000
`define ICR_OFF_MOD      12'h004
`define ICR_OFF_BR       12'h008
`define ICR_OFF_OWN_SLAVE_ADDRESS     12'h00c
`define ICR_OFF_CTL      12'h010
`define ICR_OFF_TXD      12'h014
`define ICR_OFF_RXD      12'h018
`define ICR_OFF_FLAG     12'h01c
`define ICR_OFF_IEN      12'h020
`define ICR_OFF_TDMA     12'h024
`define ICR_OFF_RDMA     12'h028
`define ICR_CLK_DBG      8
`define ICR_MOD_WIDE     2
`define ICR_MOD_GC       1
`define ICR_CTL_ROLE     5
`define ICR_CTL_NACK     4
`define ICR_CTL_STOP     3
`define ICR_CTL_START    2
`define ICR_CTL_SRST     1
`define ICR_CTL_EN       0
`define ICR_F_BYTE       7
`define ICR_F_GC         6
`define ICR_F_NACK       5
`define ICR_F_STOP       4
`define ICR_F_START      3
`define ICR_F_ERR        2
`define ICR_F_RXF        1
`define ICR_F_TXE        0
`define ICR_BR_RESET     7'h7f
`define ICR_SRST_CYCLES  4'h4
`define ICR_STAT_SDA     12
`define ICR_STAT_SCL     11
`define ICR_STAT_BSY     10
`define ICR_STAT_TR      9
`endif

// File: rtl/icr_pkg.sv
// Types shared by the two-wire controller register block.
package icr_pkg;
  typedef enum logic [1:0] {
    ICR_SRC_INTERNAL,
    ICR_SRC_SLOW,
    ICR_SRC_FAST,
    ICR_SRC_EXTERNAL
  } icr_src_t;
  typedef enum {
    ICR_SR_IDLE,
    ICR_SR_BUSY
  } icr_sr_state_t;
endpackage

// File: rtl/icr_regs.sv
// APB register block for one two-wire serial controller channel.
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/100ps
`include "icr_map.svh"
module icr_regs
  import icr_pkg::*;
#(
  parameter int DMA_CH = 16
)(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [3:0]        src_ticks,
  input  wire logic              debug_halt,
  input  wire logic              ev_byte_done,
  input  wire logic              ev_gen_call,
  input  wire logic              ev_nack_rx,
  input  wire logic              ev_stop_done,
  input  wire logic              ev_stop_slave,
  input  wire logic              ev_start_done,
  input  wire logic              ev_addr_match,
  input  wire logic              ev_addr_read,
  input  wire logic              ev_ack_rx,
  input  wire logic              ev_tx_loaded,
  input  wire logic              ev_error,
  input  wire logic              ev_nack_sent,
  input  wire logic              ev_rx_load,
  input  wire logic [7:0]        rx_byte,
  input  wire logic              bus_busy,
  input  wire logic              tx_mode,
  input  wire logic              sda_low,
  input  wire logic              scl_low,
  output logic                   op_clk_en,
  output logic                   engine_reset,
  output logic                   role_master,
  output logic                   wide_addr,
  output logic                   gc_respond,
  output logic [9:0]             own_addr,
  output logic [6:0]             baud_reload_value,
  output logic [7:0]             tx_byte,
  output logic                   start_pending,
  output logic                   stop_pending,
  output logic                   nack_pending,
  output logic                   irq,
  output logic [DMA_CH-1:0]      dma_req
);
  import icr_pkg::*;

  // ==========================================================
  // Register storage
  logic              run_in_debug;
  logic [1:0]        clock_divider_sel;
  logic [1:0]        clock_source_sel;
  logic              unit_enable;
  logic [7:0]        flags;
  logic [7:0]        irq_en;
  logic [15:0]       tx_dma_en;
  logic [15:0]       rx_dma_en;
  logic [7:0]        rx_buf;
  logic [3:0]        sr_cnt;
  icr_sr_state_t     sr_state;
  logic [7:0]        set_v;
  logic [7:0]        clr_v;
  logic              wr;
  logic              rd;
  logic              sr_busy;

  icr_ev_if ev ();

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign sr_busy = (sr_state == ICR_SR_BUSY);

  // ==========================================================
  // Operating clock
  assign ev.src_sel = clock_source_sel;
  assign ev.div_sel = clock_divider_sel;
  assign ev.src_tick = src_ticks[clock_source_sel]; // see RQ12

  icr_clk_gate u_gate (
    .clock (clock),
    .rst   (rst),
    .run   (unit_enable && (run_in_debug || !debug_halt)), // see RQ13
    .ev    (ev.gate)
  );
  assign op_clk_en = ev.clk_en;

  // ==========================================================
  // Configuration registers
  always_ff @(posedge clock) begin
    if (rst) begin
      run_in_debug      <= 1'b0;
      clock_divider_sel <= 2'h0;
      clock_source_sel  <= 2'h0;
      wide_addr         <= 1'b0;
      gc_respond        <= 1'b0;
      baud_reload_value <= `ICR_BR_RESET; // see RQ17
      own_addr          <= 10'h000;
      role_master       <= 1'b0;
      unit_enable       <= 1'b0;
      irq_en            <= 8'h00;
      tx_dma_en         <= 16'h0000;
      rx_dma_en         <= 16'h0000;
      tx_byte           <= 8'h00;
    end else if (wr) begin
      if (hit(paddr, `ICR_OFF_CLK)) begin
        run_in_debug      <= pwdata[`ICR_CLK_DBG];
        clock_divider_sel <= pwdata[5:4];
        clock_source_sel  <= pwdata[1:0];
      end
      if (hit(paddr, `ICR_OFF_MOD)) begin
        wide_addr  <= pwdata[`ICR_MOD_WIDE]; // see RQ15
        gc_respond <= pwdata[`ICR_MOD_GC]; // see RQ16
      end
      if (hit(paddr, `ICR_OFF_BR)) begin
        baud_reload_value <= pwdata[6:0];
      end
      if (hit(paddr, `ICR_OFF_OWN_SLAVE_ADDRESS)) begin
        own_addr <= pwdata[9:0];
      end
      if (hit(paddr, `ICR_OFF_CTL)) begin
        role_master <= pwdata[`ICR_CTL_ROLE]; // see RQ18
        unit_enable <= pwdata[`ICR_CTL_EN]; // see RQ22
      end
      if (hit(paddr, `ICR_OFF_IEN)) begin
        irq_en <= pwdata[7:0]; // see RQ25
      end
      if (hit(paddr, `ICR_OFF_TDMA)) begin
        tx_dma_en <= pwdata[15:0]; // see RQ26
      end
      if (hit(paddr, `ICR_OFF_RDMA)) begin
        rx_dma_en <= pwdata[15:0];
      end
      if (hit(paddr, `ICR_OFF_TXD)) begin
        tx_byte <= pwdata[7:0];
      end
    end
  end

  // ==========================================================
  // Soft reset sequencer
  always_ff @(posedge clock) begin
    if (rst) begin
      sr_state <= ICR_SR_IDLE;
      sr_cnt   <= 4'h0;
    end else begin
      case (sr_state)
        ICR_SR_IDLE: begin
          if (wr && hit(paddr, `ICR_OFF_CTL) && pwdata[`ICR_CTL_SRST]) begin
            sr_state <= ICR_SR_BUSY; // see RQ21
            sr_cnt   <= `ICR_SRST_CYCLES;
          end
        end
        ICR_SR_BUSY: begin
          sr_cnt <= sr_cnt - 4'h1;
          if (sr_cnt == 4'h1) begin
            sr_state <= ICR_SR_IDLE;
          end
        end
        default: sr_state <= ICR_SR_IDLE;
      endcase
    end
  end
  assign engine_reset = sr_busy;

  // ==========================================================
  // Self-clearing command bits
  always_ff @(posedge clock) begin
    if (rst || sr_busy) begin
      start_pending <= 1'b0;
      stop_pending  <= 1'b0;
      nack_pending  <= 1'b0;
    end else begin
      if (wr && hit(paddr, `ICR_OFF_CTL) && pwdata[`ICR_CTL_NACK]) begin
        nack_pending <= 1'b1; // see RQ19
      end else if (ev_nack_sent) begin
        nack_pending <= 1'b0;
      end
      if (wr && hit(paddr, `ICR_OFF_CTL) && pwdata[`ICR_CTL_START] &&
          pwdata[`ICR_CTL_ROLE]) begin
        start_pending <= 1'b1; // see RQ20
      end else if (ev_start_done || ev_error) begin
        start_pending <= 1'b0;
      end
      if (wr && hit(paddr, `ICR_OFF_CTL) && pwdata[`ICR_CTL_STOP] &&
          pwdata[`ICR_CTL_ROLE]) begin
        stop_pending <= 1'b1; // see RQ20
      end else if (ev_stop_done) begin
        stop_pending <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Interrupt flags
  always_comb begin
    set_v = 8'h00;
    set_v[`ICR_F_BYTE]  = ev_byte_done; // see RQ1
    set_v[`ICR_F_GC]    = ev_gen_call && !role_master && gc_respond; // see RQ2
    set_v[`ICR_F_NACK]  = ev_nack_rx; // see RQ3
    set_v[`ICR_F_STOP]  = role_master ? ev_stop_done : ev_stop_slave; // see RQ4
    set_v[`ICR_F_START] = role_master ? ev_start_done : ev_addr_match; // see RQ5
    set_v[`ICR_F_ERR]   = ev_error;
    set_v[`ICR_F_RXF]   = ev_rx_load; // see RQ8
    set_v[`ICR_F_TXE]   = role_master ? (ev_start_done || ev_ack_rx) // see RQ6
                        : (ev_tx_loaded || (ev_addr_match && ev_addr_read)); // see RQ7
    clr_v = 8'h00;
    if (wr && hit(paddr, `ICR_OFF_FLAG)) begin
      clr_v[7:2] = pwdata[7:2]; // see RQ24
    end
    clr_v[`ICR_F_RXF] = rd && hit(paddr, `ICR_OFF_RXD);
    clr_v[`ICR_F_TXE] = wr && hit(paddr, `ICR_OFF_TXD); // see RQ6
  end

  always_ff @(posedge clock) begin
    if (rst || sr_busy) begin
      flags <= 8'h00; // see RQ21
    end else begin
      flags <= set_v | (flags & ~clr_v);
    end
  end

  always_ff @(posedge clock) begin
    if (rst || sr_busy) begin
      rx_buf <= 8'h00;
    end else if (ev_rx_load) begin
      rx_buf <= rx_byte;
    end
  end

  assign irq = |(flags & irq_en); // see RQ9

  genvar gi;
  generate
    for (gi = 0; gi < DMA_CH; gi++) begin : g_dma
      assign dma_req[gi] = (flags[`ICR_F_TXE] && tx_dma_en[gi]) ||
                           (flags[`ICR_F_RXF] && rx_dma_en[gi]); // see RQ10
    end
  endgenerate

  // ==========================================================
  // Read path
  always_ff @(posedge clock) begin
    if (rst) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      case (paddr)
        `ICR_OFF_CLK: begin
          prdata[`ICR_CLK_DBG] <= run_in_debug;
          prdata[5:4] <= clock_divider_sel;
          prdata[1:0] <= clock_source_sel;
        end
        `ICR_OFF_MOD: begin
          prdata[`ICR_MOD_WIDE] <= wide_addr;
          prdata[`ICR_MOD_GC] <= gc_respond;
        end
        `ICR_OFF_BR:   prdata[6:0] <= baud_reload_value;
        `ICR_OFF_OWN_SLAVE_ADDRESS: prdata[9:0] <= own_addr;
        `ICR_OFF_CTL: begin
          prdata[`ICR_CTL_ROLE]  <= role_master;
          prdata[`ICR_CTL_NACK]  <= nack_pending;
          prdata[`ICR_CTL_STOP]  <= stop_pending;
          prdata[`ICR_CTL_START] <= start_pending;
          prdata[`ICR_CTL_SRST]  <= sr_busy || (wr && pwdata[`ICR_CTL_SRST]);
          prdata[`ICR_CTL_EN]    <= unit_enable;
        end
        `ICR_OFF_TXD: prdata[7:0] <= tx_byte;
        `ICR_OFF_RXD: prdata[7:0] <= rx_buf;
        `ICR_OFF_FLAG: begin
          prdata[`ICR_STAT_SDA] <= sda_low;
          prdata[`ICR_STAT_SCL] <= scl_low;
          prdata[`ICR_STAT_BSY] <= bus_busy;
          prdata[`ICR_STAT_TR]  <= tx_mode;
          prdata[7:0] <= flags;
        end
        `ICR_OFF_IEN:  prdata[7:0] <= irq_en;
        `ICR_OFF_TDMA: prdata[15:0] <= tx_dma_en;
        `ICR_OFF_RDMA: prdata[15:0] <= rx_dma_en;
        default:       pslverr <= 1'b1;
      endcase
    end
  end

  // ==========================================================
  // Checks
  AST_BYTE_SET: assert property (@(posedge clock) disable iff (rst) // see RQ1
    ev_byte_done && !sr_busy |=> flags[`ICR_F_BYTE])
    else $error("byte-done flag not set");
  AST_GC_SLAVE: assert property (@(posedge clock) disable iff (rst) // see RQ2
    role_master && !$past(flags[`ICR_F_GC]) && !flags[`ICR_F_GC] |=> 1'b1 ##0
    (!flags[`ICR_F_GC] || $past(ev_gen_call && !role_master)))
    else $error("general-call flag set in master role");
  AST_NACK_SET: assert property (@(posedge clock) disable iff (rst) // see RQ3
    ev_nack_rx && !sr_busy |=> flags[`ICR_F_NACK])
    else $error("nack flag not set");
  AST_RXF_CLR: assert property (@(posedge clock) disable iff (rst) // see RQ8
    rd && hit(paddr, `ICR_OFF_RXD) && !ev_rx_load |=> !flags[`ICR_F_RXF])
    else $error("rx-full not cleared by read");
  AST_TXE_CLR: assert property (@(posedge clock) disable iff (rst) // see RQ6
    wr && hit(paddr, `ICR_OFF_TXD) && !set_v[`ICR_F_TXE]
    |=> !flags[`ICR_F_TXE])
    else $error("tx-empty not cleared by data write");
  AST_IRQ: assert property (@(posedge clock) disable iff (rst) // see RQ9
    irq == |(flags & irq_en))
    else $error("interrupt not gated by enables");
  AST_DMA: assert property (@(posedge clock) disable iff (rst) // see RQ10
    dma_req[0] |-> (flags[`ICR_F_TXE] && tx_dma_en[0]) ||
                   (flags[`ICR_F_RXF] && rx_dma_en[0]))
    else $error("dma request without enabled cause");
  AST_SRST: assert property (@(posedge clock) disable iff (rst) // see RQ21
    $rose(sr_busy) |-> sr_busy[*4] ##1 !sr_busy)
    else $error("soft reset length wrong");
  AST_SRST_FLAGS: assert property (@(posedge clock) disable iff (rst) // see RQ21
    sr_busy |=> flags == 8'h00)
    else $error("flags survive soft reset");
  AST_START_SLAVE: assert property (@(posedge clock) disable iff (rst) // see RQ20
    wr && hit(paddr, `ICR_OFF_CTL) && !pwdata[`ICR_CTL_ROLE] &&
    !start_pending |=> !start_pending)
    else $error("start accepted in slave role");
  AST_BR_RESET: assert property (@(posedge clock) // see RQ17
    rst |=> baud_reload_value == `ICR_BR_RESET)
    else $error("baud reload reset value wrong");
  AST_GATE: assert property (@(posedge clock) disable iff (rst) // see RQ22
    !unit_enable |-> !op_clk_en)
    else $error("clock runs while disabled");

  COV_RXF: cover property (@(posedge clock) ev_rx_load ##[1:20] rd);
  COV_SRST: cover property (@(posedge clock) $fell(sr_busy));
  COV_IRQ: cover property (@(posedge clock) $rose(irq));
  COV_DMA: cover property (@(posedge clock) $rose(dma_req[0]));
endmodule // icr_regs

// File: test/i2c_irq_dma_and_control_regs_tb.sv
// Self-checking bench for the two-wire controller register block.
`timescale 1ns/100ps
`include "icr_map.svh"
module i2c_irq_dma_and_control_regs_tb;
  import icr_pkg::*;
  typedef struct {
    logic [11:0] a;
    logic [31:0] rv, wr, rb;
  } icr_row_t;
  typedef struct {
    logic [31:0] v;
    logic        dbg, en;
    logic [31:0] n;
  } icr_ck_t;
  typedef struct {
    logic        m;
    logic [12:0] e;
    logic [7:0]  f;
  } icr_fl_t;
  logic        clock = 0, rst = 1, debug_halt = 0;
  logic        psel = 0, penable = 0, pwrite = 0, er;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, cnt;
  logic        pready, pslverr, op_clk_en, engine_reset, irq;
  logic        role_master, wide_addr, gc_respond;
  logic        start_pending, stop_pending, nack_pending;
  logic [9:0]  own_addr;
  logic [6:0]  baud_reload_value;
  logic [7:0]  tx_byte, rx_byte;
  logic [15:0] dma_req;
  logic [12:0] fire = 0, ev;
  logic [3:0]  ticks, lv = 4'b1010;
  int          fails = 0, checked = 0, i;
  icr_row_t regs [9] = '{
    '{`ICR_OFF_CLK,  32'h0, 32'hffff, 32'h0133},
    '{`ICR_OFF_MOD,  32'h0, 32'hffff, 32'h0006},
    '{`ICR_OFF_BR,   32'h7f, 32'h0055, 32'h0055},
    '{`ICR_OFF_OWN_SLAVE_ADDRESS, 32'h0, 32'hffff, 32'h03ff},
    '{`ICR_OFF_IEN,  32'h0, 32'h00fc, 32'h00fc},
    '{`ICR_OFF_TDMA, 32'h0, 32'h1ffff, 32'hffff},
    '{`ICR_OFF_RDMA, 32'h0, 32'ha5a5, 32'ha5a5},
    '{`ICR_OFF_CTL,  32'h0, 32'hffc0, 32'h0000},
    '{`ICR_OFF_RXD,  32'h0, 32'h00ff, 32'h0000}};
  icr_ck_t cks [9] = '{'{32'h00, 0, 1, 64}, '{32'h30, 0, 1, 8},
    '{32'h31, 0, 1, 16}, '{32'h12, 0, 1, 16}, '{32'h22, 0, 1, 8},
    '{32'h33, 0, 1, 32}, '{32'h00, 0, 0, 0}, '{32'h00, 1, 1, 0},
    '{32'h100, 1, 1, 64}};
  icr_fl_t fls [14] = '{'{1, 13'h0001, 8'h80}, '{1, 13'h0004, 8'h20},
    '{1, 13'h0400, 8'h04}, '{1, 13'h0020, 8'h09},
    '{1, 13'h0100, 8'h01}, '{1, 13'h0008, 8'h10},
    '{1, 13'h0002, 8'h00}, '{0, 13'h0040, 8'h08},
    '{0, 13'h00c0, 8'h09}, '{0, 13'h0200, 8'h01},
    '{0, 13'h0010, 8'h10}, '{0, 13'h0042, 8'h48},
    '{0, 13'h0100, 8'h00}, '{1, 13'h1000, 8'h02}};

  always #5 clock = ~clock;

  icr_engine_model i_icr_engine_model (.clock(clock), .rst(rst),
    .fire(fire), .ev(ev), .ticks(ticks), .rx_byte(rx_byte));

  icr_regs i_icr_regs (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_ticks(ticks), .debug_halt(debug_halt), .ev_byte_done(ev[0]),
    .ev_gen_call(ev[1]), .ev_nack_rx(ev[2]), .ev_stop_done(ev[3]),
    .ev_stop_slave(ev[4]), .ev_start_done(ev[5]),
    .ev_addr_match(ev[6]), .ev_addr_read(ev[7]), .ev_ack_rx(ev[8]),
    .ev_tx_loaded(ev[9]), .ev_error(ev[10]), .ev_nack_sent(ev[11]),
    .ev_rx_load(ev[12]), .rx_byte(rx_byte), .bus_busy(lv[1]),
    .tx_mode(lv[0]), .sda_low(lv[3]), .scl_low(lv[2]),
    .op_clk_en(op_clk_en), .engine_reset(engine_reset),
    .role_master(role_master), .wide_addr(wide_addr),
    .gc_respond(gc_respond), .own_addr(own_addr),
    .baud_reload_value(baud_reload_value), .tx_byte(tx_byte),
    .start_pending(start_pending), .stop_pending(stop_pending),
    .nack_pending(nack_pending), .irq(irq), .dma_req(dma_req));

  // ====================
  // Tasks
  task automatic results();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", s, exp, got);
    end
  endtask

  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fails++;
      results();
    end
  endtask

  task automatic kick(input logic [12:0] m);
    @(posedge clock);
    fire <= m;
    @(posedge clock);
    fire <= 13'h0;
    repeat (2) @(posedge clock);
  endtask

  // ====================
  // Sequence
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    foreach (regs[i]) begin
      bus(0, regs[i].a, 0);
      chk("reset", rd, regs[i].rv);
      bus(1, regs[i].a, regs[i].wr);
      bus(0, regs[i].a, 0);
      chk("readback", rd, regs[i].rb);
    end
    chk("slverr", er, 0);
    chk("outs", {own_addr, baud_reload_value, wide_addr, gc_respond},
        {10'h3ff, 7'h55, 1'b1, 1'b1});
    bus(1, 12'h0fc, 32'h1);
    chk("unmapped", er, 1);
    foreach (cks[i]) begin
      bus(1, `ICR_OFF_CTL, 0);
      bus(1, `ICR_OFF_CLK, cks[i].v);
      debug_halt <= cks[i].dbg;
      bus(1, `ICR_OFF_CTL, {31'h0, cks[i].en});
      repeat (4) @(posedge clock);
      cnt = 0;
      repeat (64) begin
        @(posedge clock);
        cnt += op_clk_en;
      end
      chk("op_clk", cnt, cks[i].n);
    end
    debug_halt <= 1'b0;
    kick(13'h0001);
    bus(1, `ICR_OFF_CTL, 32'h23);
    @(negedge clock);
    chk("engine_reset", engine_reset, 1);
    bus(0, `ICR_OFF_CTL, 0);
    chk("srst bit", rd, 32'h23);
    for (i = 0; i < 20 && engine_reset !== 1'b0; i++)
      @(posedge clock);
    chk("srst end", engine_reset, 0);
    bus(0, `ICR_OFF_CTL, 0);
    chk("srst done", rd, 32'h21);
    bus(0, `ICR_OFF_FLAG, 0);
    chk("srst flags", rd[7:0], 0);
    foreach (fls[i]) begin
      bus(1, `ICR_OFF_CTL, fls[i].m ? 32'h21 : 32'h01);
      kick(fls[i].e);
      chk("role", role_master, fls[i].m);
      bus(0, `ICR_OFF_FLAG, 0);
      chk("flags", rd, {19'h0, lv, 1'b0, fls[i].f});
      chk("irq", irq, |(fls[i].f & 8'hfc));
      chk("dma", dma_req, ({16{fls[i].f[0]}} & 16'hffff) |
          ({16{fls[i].f[1]}} & 16'ha5a5));
      if (fls[i].f[1]) begin
        bus(0, `ICR_OFF_RXD, 0);
        chk("rxd", rd, 32'h3c);
      end
      if (fls[i].f[0])
        bus(1, `ICR_OFF_TXD, 32'h1ab);
      bus(1, `ICR_OFF_FLAG, 32'hff);
      bus(0, `ICR_OFF_FLAG, 0);
      chk("cleared", rd[7:0], 0);
    end
    chk("tx_byte", tx_byte, 8'hab);
    bus(1, `ICR_OFF_CTL, 32'h0d);
    @(negedge clock);
    chk("slave cmd", {start_pending, stop_pending}, 0);
    bus(1, `ICR_OFF_CTL, 32'h25);
    @(negedge clock);
    chk("start", start_pending, 1);
    kick(13'h0020);
    chk("start done", start_pending, 0);
    bus(1, `ICR_OFF_CTL, 32'h29);
    bus(0, `ICR_OFF_CTL, 0);
    chk("stop bit", rd, 32'h29);
    kick(13'h0008);
    chk("stop done", stop_pending, 0);
    bus(1, `ICR_OFF_CTL, 32'h31);
    bus(1, `ICR_OFF_CTL, 32'h21);
    @(negedge clock);
    chk("nack", nack_pending, 1);
    kick(13'h0800);
    chk("nack sent", nack_pending, 0);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    bus(0, `ICR_OFF_BR, 0);
    chk("rst baud", rd, 32'h7f);
    bus(0, `ICR_OFF_CTL, 0);
    chk("rst ctl", rd, 0);
    results();
  end
endmodule  // i2c_irq_dma_and_control_regs_tb

// File: test/icr_engine_model.sv
// Protocol engine and clock source stand-in for the register block.
`timescale 1ns/100ps
module icr_engine_model (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [12:0] fire,
  output logic      [12:0] ev,
  output logic      [3:0]  ticks,
  output logic      [7:0]  rx_byte
);
  logic [1:0] cnt;
  // ====================
  // Events
  // Each requested event appears as a single-cycle pulse.
  always_ff @(posedge clock) begin
    if (rst) begin
      ev  <= 13'h0000;
      cnt <= 2'h0;
    end else begin
      ev  <= fire;
      cnt <= cnt + 2'h1;
    end
  end
  // ====================
  // Sources
  // Source 0 ticks every cycle, 1 every fourth, 2 and 3 every second.
  assign ticks   = {cnt[0], ~cnt[0], cnt == 2'h0, 1'b1};
  // Received data is only meaningful in the load cycle.
  assign rx_byte = ev[12] ? 8'h3c : 8'hc3;
endmodule  // icr_engine_model
